/* File: shared/awe_pkg.sv */
// Summary of operation
// - The 17-bit field of the second PCI window stop register sets the last address of that space.
// - The 17-bit field of the boot window start register sets the first boot address; the rest is reserved.
// - At reset the boot window start loads a low or a high value picked by the boot strap.
// - The low start value means address zero and the high start value means 0xFFF0_0000.
// - At reset the boot window stop field loads a low or high value picked by the same strap.
// - The low stop value covers up to 0x0007_FFFF and the high stop value ends the high window.
// - Either way the boot window after reset spans 512 kilobytes.
// - The boot space decodes only while the boot enable bit is set.
// - The first PCI window decodes only while its enable bit is set.
// - The second PCI window decodes only while its enable bit is set.
// - The SDRAM window decodes only while its enable bit is set.
// - Each chip select window five down to zero decodes only while its own enable bit is set.
// - The other bits of the enable register are reserved and carry no enable.
// - Every other window has start and stop registers holding the same 17-bit field.
package awe_pkg;

   localparam int unsigned NUM_WIN  = 10;
   localparam int unsigned FIELD_W  = 17;
   localparam int unsigned ADDR_LSB = 15;   // field holds address bits 31..15

   // window indices
   localparam int unsigned WIN_SDRAM = 6;
   localparam int unsigned WIN_PCI1  = 7;
   localparam int unsigned WIN_PCI2  = 8;
   localparam int unsigned WIN_BOOT  = 9;

   // register byte offsets; window w start at 0x04 + 8*w, stop 4 bytes later
   localparam logic [7:0] WIN_BASE_OFFS   = 8'h04;
   localparam logic [7:0] PCI2_STOP_OFFS  = 8'h48;
   localparam logic [7:0] BOOT_START_OFFS = 8'h4C;
   localparam logic [7:0] BOOT_STOP_OFFS  = 8'h50;
   localparam logic [7:0] ENABLES_OFFS    = 8'h54;

   // enable bit positions (little-endian numbering)
   localparam int unsigned EN_CS0_BIT   = 16;
   localparam int unsigned EN_CS1_BIT   = 17;
   localparam int unsigned EN_CS2_BIT   = 18;
   localparam int unsigned EN_CS3_BIT   = 19;
   localparam int unsigned EN_CS4_BIT   = 20;
   localparam int unsigned EN_CS5_BIT   = 21;
   localparam int unsigned EN_SDRAM_BIT = 22;
   localparam int unsigned EN_PCI2_BIT  = 23;
   localparam int unsigned EN_PCI1_BIT  = 24;
   localparam int unsigned EN_BOOT_BIT  = 25;
   localparam int unsigned EN_POS [NUM_WIN] = '{EN_CS0_BIT, EN_CS1_BIT, EN_CS2_BIT,
      EN_CS3_BIT, EN_CS4_BIT, EN_CS5_BIT, EN_SDRAM_BIT, EN_PCI1_BIT, EN_PCI2_BIT, EN_BOOT_BIT};

   // reset values
   localparam logic [31:0]        ENABLES_MASK    = 32'h03FF0000;
   localparam logic [31:0]        ENABLES_RESET   = 32'h02000000;
   localparam logic [FIELD_W-1:0] WIN_FIELD_RESET = 17'h1FFFF;
   localparam logic [FIELD_W-1:0] BOOT_START_LOW  = 17'h00000;
   localparam logic [FIELD_W-1:0] BOOT_START_HIGH = 17'h1FFE0;
   localparam logic [FIELD_W-1:0] BOOT_STOP_LOW   = 17'h0000F;
   localparam logic [FIELD_W-1:0] BOOT_STOP_HIGH  = 17'h1FFEF;
   localparam logic [FIELD_W-1:0] BOOT_SPAN_UNITS = 17'h0000F; // 16 units of 32 KB

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [FIELD_W-1:0] start;
      logic [FIELD_W-1:0] stop;
   } awe_bounds_s;

endpackage : awe_pkg

/* File: core/awe_addr_map.sv */
`timescale 1ns/10ps
module awe_addr_map
   import awe_pkg::*;
#(
   parameter int unsigned AXI_ADDR_W = 8
) (
   input  wire logic                  ref_clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic                  boot_high_strap_i,
   input  wire logic [31:0]           dec_addr_i,
   input  wire logic                  dec_valid_i,
   output logic      [NUM_WIN-1:0]    win_sel_o,
   output logic                       win_hit_o,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic                  s_axi_awvalid_i,
   output logic                       s_axi_awready_o,
   input  wire logic [31:0]           s_axi_wdata_i,
   input  wire logic [3:0]            s_axi_wstrb_i,
   input  wire logic                  s_axi_wvalid_i,
   output logic                       s_axi_wready_o,
   output logic      [1:0]            s_axi_bresp_o,
   output logic                       s_axi_bvalid_o,
   input  wire logic                  s_axi_bready_i,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic                  s_axi_arvalid_i,
   output logic                       s_axi_arready_o,
   output logic      [31:0]           s_axi_rdata_o,
   output logic      [1:0]            s_axi_rresp_o,
   output logic                       s_axi_rvalid_o,
   input  wire logic                  s_axi_rready_i
);

   // the map needs byte offsets up to 0x57
   if (AXI_ADDR_W < 8 || AXI_ADDR_W > 32) begin : g_bad_width
      $error("awe_addr_map: AXI_ADDR_W must lie in 8..32");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // true when the word address hits a register; upper address bits must be zero
   function automatic logic is_mapped(input logic [AXI_ADDR_W-1:0] a);
      logic [5:0] word;
      word = a[7:2];
      return (a >> 8) == '0 && word >= 6'd1 && word <= ENABLES_OFFS[7:2];
   endfunction : is_mapped

   // byte-lane merge of new data into an old register image
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////////
   // write channel: address and data caught in either order

   logic                  aw_full_reg, aw_full_next;
   logic [AXI_ADDR_W-1:0] awaddr_reg, awaddr_next;
   logic                  w_full_reg, w_full_next;
   logic [31:0]           wdata_reg, wdata_next;
   logic [3:0]            wstrb_reg, wstrb_next;
   logic                  bvalid_reg, bvalid_next;
   logic [1:0]            bresp_reg, bresp_next;
   logic                  wr_fire;
   logic                  wr_hit;

   // no new beat is taken while a response waits, so one write is in flight
   assign s_axi_awready_o = !aw_full_reg && !bvalid_reg;
   assign s_axi_wready_o  = !w_full_reg && !bvalid_reg;
   assign wr_fire         = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wr_hit          = is_mapped(awaddr_reg);
   assign s_axi_bvalid_o  = bvalid_reg;
   assign s_axi_bresp_o   = bresp_reg;

   // next state of the write handshake
   always_comb begin
      aw_full_next = aw_full_reg;
      awaddr_next  = awaddr_reg;
      w_full_next  = w_full_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_full_next = 1'b1;
         awaddr_next  = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_full_next = 1'b1;
         wdata_next  = s_axi_wdata_i;
         wstrb_next  = s_axi_wstrb_i;
      end
      if (bvalid_reg && s_axi_bready_i) begin
         bvalid_next = 1'b0;
      end
      if (wr_fire) begin
         aw_full_next = 1'b0;
         w_full_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_hit ? RESP_OKAY : RESP_SLVERR; // unmapped gets an error
      end
      if (!rst_n_i) begin
         aw_full_next = 1'b0;
         awaddr_next  = '0;
         w_full_next  = 1'b0;
         wdata_next   = 32'h00000000;
         wstrb_next   = 4'h0;
         bvalid_next  = 1'b0;
         bresp_next   = RESP_OKAY;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      aw_full_reg <= aw_full_next;
      awaddr_reg  <= awaddr_next;
      w_full_reg  <= w_full_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register file: window bounds and the enable register

   awe_bounds_s bounds_reg [NUM_WIN];
   awe_bounds_s bounds_next [NUM_WIN];
   logic [31:0] enables_reg, enables_next;
   logic [5:0]  wr_word;

   assign wr_word = awaddr_reg[7:2];

   // one start/stop pair per window, all with the same 17-bit field
   for (genvar w = 0; w < NUM_WIN; w++) begin : g_bounds
      localparam logic [5:0] START_WORD = 6'(2 * w + 1);
      always_comb begin
         bounds_next[w] = bounds_reg[w];
         if (!rst_n_i) begin
            if (w == WIN_BOOT) begin
               // strap is sampled by the synchronous reset itself
               bounds_next[w].start = boot_high_strap_i ? BOOT_START_HIGH
                                                        : BOOT_START_LOW;
               bounds_next[w].stop  = boot_high_strap_i ? BOOT_STOP_HIGH
                                                        : BOOT_STOP_LOW;
            end else begin
               bounds_next[w].start = WIN_FIELD_RESET;
               bounds_next[w].stop  = WIN_FIELD_RESET;
            end
         end else if (wr_fire && wr_hit && wr_word == START_WORD) begin
            // the size cast keeps the 17-bit field, the reserved upper bits are dropped
            bounds_next[w].start = FIELD_W'(merge({15'h0000, bounds_reg[w].start}, wdata_reg,
                                                  wstrb_reg));
         end else if (wr_fire && wr_hit && wr_word == START_WORD + 6'd1) begin
            bounds_next[w].stop = FIELD_W'(merge({15'h0000, bounds_reg[w].stop}, wdata_reg,
                                                 wstrb_reg));
         end
      end
      always_ff @(posedge ref_clk_i) begin
         bounds_reg[w] <= bounds_next[w];
      end
   end

   // enable register; reserved bits never store a one
   always_comb begin
      enables_next = enables_reg;
      if (!rst_n_i) begin
         enables_next = ENABLES_RESET;
      end else if (wr_fire && wr_hit && wr_word == ENABLES_OFFS[7:2]) begin
         enables_next = merge(enables_reg, wdata_reg, wstrb_reg) & ENABLES_MASK;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      enables_reg <= enables_next;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read channel: answer one cycle after the address is taken

   logic        rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0]  rresp_reg, rresp_next;
   logic [31:0] rd_image;
   logic [5:0]  rd_word;
   logic [3:0]  rd_win;

   assign s_axi_arready_o = !rvalid_reg;
   assign s_axi_rvalid_o  = rvalid_reg;
   assign s_axi_rdata_o   = rdata_reg;
   assign s_axi_rresp_o   = rresp_reg;
   assign rd_word         = s_axi_araddr_i[7:2];
   assign rd_win          = 4'((rd_word - 6'd1) >> 1);

   // read image; reserved bits read as zero
   always_comb begin
      rd_image = 32'h00000000;
      if (is_mapped(s_axi_araddr_i)) begin
         if (rd_word == ENABLES_OFFS[7:2]) begin
            rd_image = enables_reg;
         end else if (rd_word[0]) begin
            rd_image = {15'h0000, bounds_reg[rd_win].start};
         end else begin
            rd_image = {15'h0000, bounds_reg[rd_win].stop};
         end
      end
   end

   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (rvalid_reg && s_axi_rready_i) begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         rvalid_next = 1'b1;
         rdata_next  = rd_image;
         rresp_next  = is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end
      if (!rst_n_i) begin
         rvalid_next = 1'b0;
         rdata_next  = 32'h00000000;
         rresp_next  = RESP_OKAY;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // address decode: one registered select per window

   logic [NUM_WIN-1:0] sel_reg, sel_next;
   logic [FIELD_W-1:0] dec_upper;

   assign dec_upper = dec_addr_i[31:ADDR_LSB];

   // a window with stop below start simply never matches
   for (genvar w = 0; w < NUM_WIN; w++) begin : g_decode
      always_comb begin
         sel_next[w] = rst_n_i && dec_valid_i && enables_reg[EN_POS[w]]
                       && dec_upper >= bounds_reg[w].start
                       && dec_upper <= bounds_reg[w].stop;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      sel_reg <= sel_next;
   end

   // overlapping windows may raise several selects; priority is the consumer's
   assign win_sel_o = sel_reg;
   assign win_hit_o = |sel_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   logic past_rst_n_reg;
   always_ff @(posedge ref_clk_i) begin
      past_rst_n_reg <= rst_n_i;
   end

   boot_start_strap_a : assert property (disable iff (1'b0)
      (!past_rst_n_reg && rst_n_i) |-> bounds_reg[WIN_BOOT].start ==
         ($past(boot_high_strap_i) ? BOOT_START_HIGH : BOOT_START_LOW))
      else $error("boot start not loaded from strap");
   boot_stop_strap_a : assert property (disable iff (1'b0)
      (!past_rst_n_reg && rst_n_i) |-> bounds_reg[WIN_BOOT].stop ==
         ($past(boot_high_strap_i) ? BOOT_STOP_HIGH : BOOT_STOP_LOW))
      else $error("boot stop not loaded from strap");
   boot_span_a : assert property (disable iff (1'b0)
      (!past_rst_n_reg && rst_n_i) |->
         bounds_reg[WIN_BOOT].stop - bounds_reg[WIN_BOOT].start == BOOT_SPAN_UNITS)
      else $error("boot window after reset is not 512 KB");
   enables_reset_a : assert property (disable iff (1'b0)
      (!past_rst_n_reg && rst_n_i) |-> enables_reg == ENABLES_RESET)
      else $error("enable register reset value wrong");
   enables_reserved_a : assert property (
      (enables_reg & ~ENABLES_MASK) == 32'h00000000)
      else $error("reserved enable bit set");
   boot_sel_gate_a : assert property (
      win_sel_o[WIN_BOOT] |-> $past(enables_reg[EN_BOOT_BIT]))
      else $error("boot selected while disabled");
   pci1_sel_gate_a : assert property (
      !enables_reg[EN_PCI1_BIT] |=> !win_sel_o[WIN_PCI1])
      else $error("first pci window selected while disabled");
   pci2_sel_gate_a : assert property (
      !enables_reg[EN_PCI2_BIT] |=> !win_sel_o[WIN_PCI2])
      else $error("second pci window selected while disabled");
   sdram_sel_gate_a : assert property (
      win_sel_o[WIN_SDRAM] |-> $past(enables_reg[EN_SDRAM_BIT]))
      else $error("sdram selected while disabled");
   cs_sel_gate_a : assert property (
      (win_sel_o[5:0] & ~$past(enables_reg[EN_CS5_BIT:EN_CS0_BIT])) == 6'h00)
      else $error("chip select selected while disabled");
   boot_in_range_a : assert property (
      (dec_valid_i && enables_reg[EN_BOOT_BIT]
       && dec_upper >= bounds_reg[WIN_BOOT].start && dec_upper <= bounds_reg[WIN_BOOT].stop)
      |=> win_sel_o[WIN_BOOT])
      else $error("boot address in range not selected");
   pci2_stop_write_a : assert property (
      (wr_fire && awaddr_reg == AXI_ADDR_W'(PCI2_STOP_OFFS) && wstrb_reg == 4'hF)
      |=> bounds_reg[WIN_PCI2].stop == $past(wdata_reg[FIELD_W-1:0]) && s_axi_bvalid_o)
      else $error("second pci stop write lost");
   boot_start_write_a : assert property (
      (wr_fire && awaddr_reg == AXI_ADDR_W'(BOOT_START_OFFS) && wstrb_reg == 4'hF)
      |=> bounds_reg[WIN_BOOT].start == $past(wdata_reg[FIELD_W-1:0]))
      else $error("boot start write lost");

   boot_hit_c  : cover property (win_sel_o[WIN_BOOT]);
   write_ok_c  : cover property (s_axi_bvalid_o && s_axi_bready_i && s_axi_bresp_o == RESP_OKAY);
   read_ok_c   : cover property (s_axi_rvalid_o && s_axi_rready_i && s_axi_rresp_o == RESP_OKAY);
   unmapped_c  : cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);

endmodule : awe_addr_map

/* File: testbench/awe_dec_host.sv */
`timescale 1ns/10ps
module awe_dec_host
   import awe_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [31:0] base_i,
   input  wire logic [31:0] spread_i,
   output logic      [31:0] dec_addr_o,
   output logic             dec_valid_o
);
   logic [31:0] rnd;

   // bus starts idle so the decoder never sees an unknown address
   initial begin
      dec_addr_o  = 32'h0;
      dec_valid_o = 1'b0;
   end

   // one offer per cycle; with a spread, one cycle in eight goes idle
   always @(posedge ref_clk_i) begin
      rnd = $urandom;
      if (rst_n_i && (spread_i == 32'h0 || rnd[2:0] != 3'h0)) begin
         dec_valid_o <= 1'b1;
         dec_addr_o  <= base_i ^ (rnd & spread_i);
      end else begin
         dec_valid_o <= 1'b0;
         dec_addr_o  <= ~dec_addr_o; // idle bus does not keep the old address
      end
   end
endmodule : awe_dec_host

/* File: testbench/awe_addr_map_tb.sv */
`timescale 1ns/10ps
module awe_addr_map_tb
   import awe_pkg::*;
;
   logic               ref_clk_i = 1'b0;
   logic               rst_n_i   = 1'b0;
   logic               strap     = 1'b1;
   logic [31:0]        base      = 32'h0;
   logic [31:0]        spread    = 32'h0;
   logic [31:0]        dec_addr;
   logic               dec_valid;
   logic [NUM_WIN-1:0] win_sel;
   logic               win_hit;
   logic [7:0]         awaddr = 8'h0;
   logic [7:0]         araddr = 8'h0;
   logic [31:0]        wdata  = 32'h0;
   logic [3:0]         wstrb  = 4'h0;
   logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic               arvalid = 1'b0, rready = 1'b0;
   logic               awready, wready, bvalid, arready, rvalid;
   logic [1:0]         bresp, rresp;
   logic [31:0]        rdata;
   logic [31:0]        mreg [0:21];
   int                 enb [NUM_WIN] = '{16, 17, 18, 19, 20, 21, 22, 24, 23, 25};
   int                 bad_count = 0;
   int                 checks_done = 0;
   bit                 chk_en = 1'b0;
   logic [31:0]        sa = 32'h0;
   logic               sv = 1'b0;

   awe_dec_host host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .base_i(base),
      .spread_i(spread), .dec_addr_o(dec_addr), .dec_valid_o(dec_valid));

   awe_addr_map uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .boot_high_strap_i(strap),
      .dec_addr_i(dec_addr), .dec_valid_i(dec_valid), .win_sel_o(win_sel), .win_hit_o(win_hit),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop

   // register image after reset; boot window derived from base and 512 KB span
   task automatic model_rst(input logic s);
      for (int i = 0; i < 22; i++) mreg[i] = 32'h0001FFFF;
      mreg[19] = s ? (32'hFFF00000 >> 15) : 32'h0;
      mreg[20] = mreg[19] + (512 * 1024 / 32768) - 1;
      mreg[21] = 32'h02000000;
   endtask : model_rst

   function automatic logic [NUM_WIN-1:0] model_sel(input logic [31:0] a, input logic v);
      logic [NUM_WIN-1:0] s;
      s = '0;
      for (int w = 0; w < NUM_WIN; w++)
         s[w] = v && mreg[21][enb[w]] && a[31:15] >= mreg[1+2*w][16:0]
                && a[31:15] <= mreg[2+2*w][16:0];
      return s;
   endfunction : model_sel

   // write: both beats offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ok, awh, wh, bh;
      logic [1:0] r;
      logic [31:0] m;
      chk_en = 1'b0;
      ok = a >= 8'h04 && a <= 8'h54;
      @(posedge ref_clk_i);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(negedge ref_clk_i);
         awh = awvalid && awready;
         wh  = wvalid && wready;
         @(posedge ref_clk_i);
         if (awh) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
      end while (awvalid && !awh || wvalid && !wh);
      bready <= 1'b1;
      do begin
         @(negedge ref_clk_i);
         bh = bvalid;
         r  = bresp;
         @(posedge ref_clk_i);
      end while (!bh);
      bready <= 1'b0;
      check({30'h0, r}, ok ? RESP_OKAY : RESP_SLVERR);
      m = (a == 8'h54) ? 32'h03FF0000 : 32'h0001FFFF;
      for (int b = 0; b < 4; b++)
         if (ok && s[b]) mreg[a[7:2]][8*b+:8] = d[8*b+:8] & m[8*b+:8];
      chk_en = 1'b1;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a);
      logic ok, h;
      logic [31:0] d;
      logic [1:0] r;
      ok = a >= 8'h04 && a <= 8'h54;
      @(posedge ref_clk_i);
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge ref_clk_i);
         h = arready;
         @(posedge ref_clk_i);
      end while (!h);
      arvalid <= 1'b0;
      rready  <= 1'b1;
      do begin
         @(negedge ref_clk_i);
         h = rvalid;
         d = rdata;
         r = rresp;
         @(posedge ref_clk_i);
      end while (!h);
      rready <= 1'b0;
      check(d, ok ? mreg[a[7:2]] : 32'h0);
      check({30'h0, r}, ok ? RESP_OKAY : RESP_SLVERR);
   endtask : axi_rd

   task automatic do_reset(input logic s);
      chk_en = 1'b0;
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      strap   <= s;
      repeat (6) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check({22'h0, win_sel}, 32'h0);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      model_rst(s);
      repeat (2) @(posedge ref_clk_i);
      chk_en = 1'b1;
   endtask : do_reset

   // fixed address; partner adds one cycle, decoder one more
   task automatic probe(input logic [31:0] a, input logic e);
      @(posedge ref_clk_i);
      base   <= a;
      spread <= 32'h0;
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check({31'h0, win_sel[WIN_BOOT]}, {31'h0, e});
   endtask : probe

   task automatic run_dec(input int n);
      @(posedge ref_clk_i);
      base   <= 32'h0;
      spread <= 32'h007FFFFF;
      repeat (n) @(posedge ref_clk_i);
   endtask : run_dec

   ////////////////////////////////////////////////////////////////////////////
   initial forever #5 ref_clk_i = ~ref_clk_i;

   // sample what the decoder sees, compare its registered answer mid-cycle
   always @(posedge ref_clk_i) begin
      sa <= dec_addr;
      sv <= dec_valid;
   end

   always @(negedge ref_clk_i) begin
      if (chk_en) check({21'h0, win_hit, win_sel}, {21'h0, |model_sel(sa, sv), model_sel(sa, sv)});
   end

   // bound well above the expected thousand or so cycles
   initial begin
      #300000;
      bad_count++;
      report_and_stop();
   end

   initial begin
      logic [16:0] st;
      void'($urandom(80));
      do_reset(1'b1);
      for (int i = 1; i < 22; i++) axi_rd(8'(4 * i));
      probe(32'hFFF00000, 1'b1);
      probe(32'hFFF7FFFF, 1'b1);
      probe(32'hFFF80000, 1'b0);
      probe(32'hFFEFFFFF, 1'b0);
      axi_wr(8'h54, 32'h0, 4'hF);
      probe(32'hFFF00000, 1'b0);
      do_reset(1'b0);
      axi_rd(8'h4C);
      axi_rd(8'h50);
      probe(32'h00000000, 1'b1);
      probe(32'h0007FFFF, 1'b1);
      probe(32'h00080000, 1'b0);
      axi_wr(8'h54, 32'hFFFFFFFF, 4'hF);
      axi_rd(8'h54);
      axi_wr(8'h48, 32'hFFFFFFFF, 4'hF);
      axi_rd(8'h48);
      axi_wr(8'h4C, 32'h12345678, 4'h2);
      axi_rd(8'h4C);
      axi_wr(8'h00, 32'hFFFFFFFF, 4'hF);
      axi_rd(8'h00);
      axi_wr(8'h58, 32'hFFFFFFFF, 4'hF);
      axi_rd(8'h58);
      // small random windows side by side so every one is hit
      for (int w = 0; w < NUM_WIN; w++) begin
         st = 17'(16 * w + $urandom % 8);
         axi_wr(8'(4 + 8 * w), {15'h0, st}, 4'hF);
         axi_wr(8'(8 + 8 * w), {15'h0, st + 17'($urandom % 16)}, 4'hF);
      end
      for (int w = 0; w < NUM_WIN; w++) begin
         axi_wr(8'h54, 32'h1 << enb[w], 4'hF);
         run_dec(40);
      end
      repeat (4) begin
         axi_wr(8'h54, $urandom, 4'hF);
         run_dec(40);
      end
      report_and_stop();
   end
endmodule : awe_addr_map_tb
